// file: cbt_pkg.sv
// package: operation codes, modes, vectors and carrier structs
package cbt_pkg;
  // ---------------------------------------------------------------
  // operations and modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_COND_JUMP, OP_COUNT_BRANCH, OP_WHILE_EQUAL,
    OP_WHILE_UNEQUAL, OP_ZERO_COUNT, OP_SOFT_INT, OP_OVERFLOW_TRAP,
    OP_RANGE_CHECK, OP_INT_RETURN, OP_CALL, OP_RETURN
  } cbt_op_t;

  typedef enum logic [1:0] {MODE_LEGACY, MODE_COMPAT, MODE_LONG} cbt_mode_t;
  typedef enum logic [1:0] {ASZ_16, ASZ_32, ASZ_64} cbt_asize_t;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_RANGE = 8'h05;
  localparam logic [7:0] VEC_UNSUPPORTED = 8'h06;
  localparam logic [3:0] SLOT_WIDE = 4'h8;
  localparam logic [3:0] SLOT_NARROW = 4'h4;
  localparam logic [3:0] INTERRUPT_RETURN_POPS_FULL = 4'h5;
  localparam logic [3:0] INTERRUPT_RETURN_POPS_SHORT = 4'h3;
  localparam logic [63:0] ZERO_64 = 64'h0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic carry;
    logic zero;
    logic overflow;
    logic parity;
    logic sign;
  } cbt_flags_t;

  typedef struct packed {
    cbt_op_t op;
    logic [3:0] cond;
    logic [7:0] vector;
    logic [31:0] disp;
    logic [63:0] nextIp;
    logic [63:0] rangeValue;
    logic [63:0] rangeLower;
    logic [63:0] rangeUpper;
    logic privChange;
  } cbt_req_t;

  typedef struct packed {
    logic branch;
    logic [63:0] target;
    logic countWrite;
    logic [63:0] countValue;
    logic exception;
    logic [7:0] vector;
    logic pushFlags;
    logic [3:0] slotBytes;
    logic [3:0] popCount;
    logic popStack;
  } cbt_res_t;
endpackage : cbt_pkg

// file: cbt_unit.sv
// count branch and trap unit: decision, count update, trap requests
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module cbt_unit (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire cbt_pkg::cbt_req_t req,
  input wire cbt_pkg::cbt_mode_t mode,
  input wire cbt_pkg::cbt_asize_t addrSize,
  input wire cbt_pkg::cbt_flags_t flags,
  input wire logic [63:0] countIn,
  output logic resValid,
  output cbt_pkg::cbt_res_t res
);
  import cbt_pkg::*;

  // ---------------------------------------------------------------
  // condition evaluation
  // ---------------------------------------------------------------
  wire logic sxo;
  wire logic condBase;
  logic condBaseSel;
  assign sxo = flags.sign ^ flags.overflow;
  // flags only, unsigned and signed groups
  always_comb begin
    unique case (req.cond[3:1])
      3'h0: condBaseSel = flags.overflow;
      3'h1: condBaseSel = flags.carry;
      3'h2: condBaseSel = flags.zero;
      3'h3: condBaseSel = flags.carry | flags.zero;
      3'h4: condBaseSel = flags.sign;
      3'h5: condBaseSel = flags.parity;
      3'h6: condBaseSel = sxo;
      3'h7: condBaseSel = sxo | flags.zero;
    endcase
  end
  assign condBase = condBaseSel ^ req.cond[0];

  // ---------------------------------------------------------------
  // count register view and decrement
  // ---------------------------------------------------------------
  wire logic [15:0] count16;
  wire logic [31:0] count32;
  wire logic [63:0] decFull;
  wire logic [63:0] decSel;
  wire logic countIsZero;
  wire logic decIsZero;
  assign count16 = countIn[15:0]; // count_reg_16
  assign count32 = countIn[31:0];
  assign decFull = countIn - 64'h1; // wraps to all ones
  // address size picks the live width
  assign decSel = (addrSize == ASZ_16) ? {countIn[63:16], decFull[15:0]} :
                  (addrSize == ASZ_32) ? {32'h0, decFull[31:0]} : decFull;
  assign countIsZero = (addrSize == ASZ_16) ? (count16 == 16'h0) :
                       (addrSize == ASZ_32) ? (count32 == 32'h0) :
                       (countIn == ZERO_64);
  assign decIsZero = (addrSize == ASZ_16) ? (decSel[15:0] == 16'h0) :
                     (addrSize == ASZ_32) ? (decSel[31:0] == 32'h0) :
                     (decSel == ZERO_64);

  // ---------------------------------------------------------------
  // target: signed 32-bit displacement on the next pointer
  // ---------------------------------------------------------------
  wire logic [63:0] dispExt;
  wire logic [63:0] targetFull;
  wire logic [63:0] targetSized;
  wire logic isLong;
  assign isLong = (mode == MODE_LONG);
  assign dispExt = {{32{req.disp[31]}}, req.disp};
  assign targetFull = req.nextIp + dispExt;
  // full 64-bit pointer in long mode, otherwise 32-bit
  assign targetSized = isLong ? targetFull : {32'h0, targetFull[31:0]};

  // ---------------------------------------------------------------
  // branch decision per operation
  // ---------------------------------------------------------------
  logic takeD;
  logic countWriteD;
  always_comb begin
    takeD = 1'b0;
    countWriteD = 1'b0;
    unique case (req.op)
      OP_COND_JUMP: takeD = condBase;
      OP_COUNT_BRANCH: begin
        countWriteD = 1'b1;
        takeD = !decIsZero;
      end
      OP_WHILE_EQUAL: begin
        countWriteD = 1'b1;
        takeD = !decIsZero && flags.zero;
      end
      OP_WHILE_UNEQUAL: begin
        countWriteD = 1'b1;
        takeD = !decIsZero && !flags.zero;
      end
      OP_ZERO_COUNT: takeD = countIsZero;
      default: takeD = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // exceptions
  // ---------------------------------------------------------------
  wire logic rangeBad;
  logic excD;
  logic [7:0] vecD;
  assign rangeBad = ($signed(req.rangeValue) < $signed(req.rangeLower)) ||
                    ($signed(req.rangeValue) > $signed(req.rangeUpper));
  always_comb begin
    excD = 1'b0;
    vecD = 8'h00;
    unique case (req.op)
      OP_SOFT_INT: begin
        excD = 1'b1;
        vecD = req.vector;
      end
      OP_OVERFLOW_TRAP: begin
        excD = flags.overflow;
        vecD = VEC_OVERFLOW;
      end
      OP_RANGE_CHECK: begin
        excD = isLong | rangeBad;
        vecD = isLong ? VEC_UNSUPPORTED : VEC_RANGE;
      end
      default: begin
        excD = 1'b0;
        vecD = 8'h00;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // stack sizing and interrupt return pops
  // ---------------------------------------------------------------
  wire logic stackOp;
  wire logic interrupt_return;
  wire logic popStackD;
  assign stackOp = (req.op == OP_CALL) || (req.op == OP_RETURN) ||
                   (req.op == OP_INT_RETURN) || excD;
  assign interrupt_return = (req.op == OP_INT_RETURN);
  // long mode always, compat only on privilege change
  assign popStackD = interrupt_return && (isLong || req.privChange);

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resValid <= 1'b0;
      res <= '0;
    end else begin
      resValid <= reqValid;
      res.branch <= reqValid && takeD;
      res.target <= takeD ? targetSized : req.nextIp;
      res.countWrite <= reqValid && countWriteD;
      res.countValue <= decSel;
      res.exception <= reqValid && excD;
      res.vector <= vecD;
      res.pushFlags <= reqValid && excD;
      res.slotBytes <= (stackOp && isLong) ? SLOT_WIDE : SLOT_NARROW;
      res.popCount <= popStackD ? INTERRUPT_RETURN_POPS_FULL :
                      (interrupt_return ? INTERRUPT_RETURN_POPS_SHORT : 4'h0);
      res.popStack <= reqValid && popStackD;
    end
  end
endmodule : cbt_unit
`default_nettype wire

// file: cbt_unit_chk.sv
// checker: decision and trap relations at the unit's ports
`timescale 1ns/100ps
`default_nettype none
module cbt_unit_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire cbt_pkg::cbt_req_t req,
  input wire cbt_pkg::cbt_mode_t mode,
  input wire cbt_pkg::cbt_asize_t addrSize,
  input wire cbt_pkg::cbt_flags_t flags,
  input wire logic [63:0] countIn,
  input wire logic resValid,
  input wire cbt_pkg::cbt_res_t res
);
  import cbt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------
  // result one cycle after each request
  // --------------------------------------------
  wire logic go = reqValid;
  wire logic cnt32 = go && req.op == OP_COUNT_BRANCH && addrSize == ASZ_32;
  property p_dec;
    cnt32 |=> res.countWrite
      && res.countValue[31:0] == $past(countIn[31:0]) - 32'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("bad count");
  property p_wrap;
    cnt32 && countIn[31:0] == 32'h0 |=> res.branch
      && res.countValue[31:0] == 32'hFFFFFFFF;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_jz;
    go && req.op == OP_ZERO_COUNT && addrSize == ASZ_32 |=> !res.countWrite
      && res.branch == ($past(countIn[31:0]) == 32'h0);
  endproperty
  a_jz: assert property (p_jz) else $error("zero test");
  property p_we;
    go && req.op == OP_WHILE_EQUAL && !flags.zero |=> !res.branch;
  endproperty
  a_we: assert property (p_we) else $error("while equal");
  property p_ovf;
    go && req.op == OP_OVERFLOW_TRAP |=> res.exception == $past(flags.overflow);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow trap");
  property p_bnd;
    go && req.op == OP_RANGE_CHECK && mode == MODE_LONG
      |=> res.exception && res.vector == VEC_UNSUPPORTED;
  endproperty
  a_bnd: assert property (p_bnd) else $error("range in long");
  property p_interrupt_return;
    go && req.op == OP_INT_RETURN && mode == MODE_LONG
      |=> res.popStack && res.slotBytes == SLOT_WIDE;
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("long return");
  property p_cmp;
    go && req.op == OP_INT_RETURN && mode == MODE_COMPAT
      |=> res.popStack == $past(req.privChange);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compat return");
endmodule : cbt_unit_chk
bind cbt_unit cbt_unit_chk u_chk (.clk(clk), .rstn(rstn), .reqValid(reqValid),
  .req(req), .mode(mode), .addrSize(addrSize), .flags(flags),
  .countIn(countIn), .resValid(resValid), .res(res));
`default_nettype wire

// file: testbench.sv
// testbench: queued expectations for branch and trap requests
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cbt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0;
  cbt_req_t req = '0;
  cbt_mode_t mode = MODE_LONG;
  cbt_asize_t addrSize = ASZ_32;
  cbt_flags_t flags = '0;
  logic [63:0] countIn = '0;
  logic resValid;
  cbt_res_t res, e, x;
  cbt_req_t r = '0;
  cbt_flags_t fl = '0;
  cbt_res_t expQ[$];
  int errors = 0;
  int check_count = 0;
  // --------------------------------------------
  // clock, unit, verdict
  // --------------------------------------------
  always #5 clk = ~clk;
  cbt_unit u_dut (.clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
    .mode(mode), .addrSize(addrSize), .flags(flags), .countIn(countIn),
    .resValid(resValid), .res(res));
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // one request per edge; expectation noted with relative target
  task automatic send(input cbt_op_t op, input logic [63:0] c,
      input cbt_asize_t a, input cbt_mode_t m);
    @(posedge clk);
    r.op = op;
    e.target = r.nextIp + {{32{r.disp[31]}}, r.disp};
    reqValid <= 1'b1;
    req <= r;
    addrSize <= a;
    mode <= m;
    flags <= fl;
    countIn <= c;
    expQ.push_back(e);
  endtask : send
  // compare each result against the oldest note
  always @(negedge clk) begin
    if (resValid === 1'b1) begin
      x = expQ.pop_front();
      check_count++;
      if (res.branch !== x.branch || res.exception !== x.exception
          || res.countWrite !== x.countWrite
          || (x.exception && res.vector !== x.vector)
          || (x.countWrite && res.countValue !== x.countValue)
          || (x.branch && res.target !== x.target)
          || res.pushFlags !== x.exception
          || res.popStack !== x.popStack
          || (x.popCount != 4'h0 && (res.popCount !== x.popCount
          || res.slotBytes !== x.slotBytes))) begin
        errors++;
        $display("[ERR] %0t result mismatch", $time);
      end
    end
  end
  initial begin
    #20000;
    errors++;
    $display("[ERR] %0t watchdog", $time);
    end_sim();
  end
  initial begin : main
    int i;
    logic [31:0] c;
    logic [7:0] v;
    void'($urandom(84535));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 24; i++) begin
      c = (i < 6) ? 32'(i % 3) : $urandom;
      fl = 5'($urandom);
      r.disp = $urandom;
      r.nextIp = {$urandom, $urandom};
      e = '0;
      e.countWrite = 1'b1;
      e.countValue = {32'h0, c - 32'h1};
      e.branch = c != 32'h1 && (i % 3 == 0 || (fl.zero ^ (i % 3 == 2)));
      send(cbt_op_t'(4'(2 + i % 3)), {$urandom, c}, ASZ_32, MODE_LONG);
    end
    for (i = 0; i < 16; i++) begin
      fl = 5'($urandom);
      r.cond = 4'(i);
      v = {(fl.sign ^ fl.overflow) | fl.zero, fl.sign ^ fl.overflow, fl.parity,
        fl.sign, fl.carry | fl.zero, fl.zero, fl.carry, fl.overflow};
      e = '0;
      e.branch = v[i / 2] ^ i[0];
      send(OP_COND_JUMP, 64'h0, ASZ_32, MODE_LONG);
    end
    fl = 5'h1F;
    e = '0;
    e.branch = 1'b1;
    e.countWrite = 1'b1;
    e.countValue = 64'h1FFFF;
    send(OP_COUNT_BRANCH, 64'h1_0000, ASZ_16, MODE_LONG);
    e.countValue = 64'hFFFFFFFF;
    send(OP_COUNT_BRANCH, 64'h1_0000_0000, ASZ_64, MODE_LONG);
    e.countWrite = 1'b0;
    send(OP_ZERO_COUNT, 64'h1_0000, ASZ_16, MODE_LONG);
    send(OP_ZERO_COUNT, 64'hFFFF_0000_0000, ASZ_32, MODE_LONG);
    e.branch = 1'b0;
    send(OP_ZERO_COUNT, 64'h1_0000, ASZ_32, MODE_LONG);
    for (i = 0; i < 8; i++) begin
      fl = 5'($urandom);
      fl.overflow = i[0];
      r.vector = 8'($urandom);
      e = '0;
      e.exception = 1'b1;
      e.vector = r.vector;
      send(OP_SOFT_INT, 64'h0, ASZ_32, MODE_LONG);
      e.exception = fl.overflow;
      e.vector = VEC_OVERFLOW;
      send(OP_OVERFLOW_TRAP, 64'h0, ASZ_32, MODE_LONG);
      r.rangeValue = 64'(i) - 64'h2;
      r.rangeLower = '1;
      r.rangeUpper = 64'h4;
      e.exception = i < 1 || i > 6;
      e.vector = VEC_RANGE;
      send(OP_RANGE_CHECK, 64'h0, ASZ_32, MODE_LEGACY);
      e.exception = 1'b1;
      e.vector = VEC_UNSUPPORTED;
      send(OP_RANGE_CHECK, 64'h0, ASZ_32, MODE_LONG);
      r.privChange = i[0];
      e = '0;
      e.popStack = i[0] || !i[1]; // long pops always, compat on change
      e.popCount = e.popStack ? INTERRUPT_RETURN_POPS_FULL : INTERRUPT_RETURN_POPS_SHORT;
      e.slotBytes = i[1] ? SLOT_NARROW : SLOT_WIDE;
      send(OP_INT_RETURN, 64'h0, ASZ_32, i[1] ? MODE_COMPAT : MODE_LONG);
    end
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
